/* design/ext_int_pkg.sv */
package ext_int_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [3:0] STATUS_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] CONFIG_TWO_ADDR = 4'h4;
    localparam logic [3:0] EVENT_STATUS_ADDR = 4'h8;
    localparam logic [3:0] EVENT_MASK_ADDR = 4'hC;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // ------------------------------------------------------------------
    // Status and control fields, and the config-two pin enable bit
    // ------------------------------------------------------------------
    localparam int MODE_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int ACK_BIT = 2;
    localparam int FLAG_BIT = 3;
    localparam int PIN_ENABLE_BIT = 0;
    // ------------------------------------------------------------------
    // Event status fields, shared constants and bus states
    // ------------------------------------------------------------------
    localparam int EV_LATCH_BIT = 0;
    localparam int EV_ACK_BIT = 1;
    localparam int EV_W = 2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic RESET_BIT = 1'h0;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } bus_state_e;
endpackage

/* design/ext_int_sync.sv */
`timescale 1ns/10ps
module ext_int_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    // ------------------------------------------------------------------
    // Two-stage synchroniser; idles high like the pulled-up pin
    // ------------------------------------------------------------------
    logic meta_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* design/external_interrupt_latch.sv */
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
// Function
// - Pin-function enable one routes the pin to the interrupt logic.
// - A falling edge on the enabled pin sets the request latch.
// - A vector fetch of this interrupt clears the latch.
// - Writing one to the acknowledge bit clears the latch.
// - Any reset clears the latch.
// - Falling edges always trigger; mode bit adds low-level triggering.
// - Edge-only: latch stays until fetch, acknowledge or reset.
// - Level mode: clear needs acknowledge and pin high, either order.
// - Level mode: request stays pending while pin remains low.
// - Reset clears latch and mode bit even with pin held low.
// - Mask bit set withholds the request from priority logic.
// - Processor global interrupt mask also blocks the request.
// - Pending flag reads independent of the mask bit.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - A falling edge after an acknowledge latches a new request.
// - Mask bit is read/write, one disables requests, reset clears.
module external_interrupt_latch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ext_int_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ext_int_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ext_int_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_int_pin_n,
    input wire logic vector_fetch,
    input wire logic cpu_global_mask,
    output logic irq_request_q,
    output logic vector_ack_q,
    output logic irq_q
);
    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic pin_sync;
    logic pin_prev_q;
    ext_int_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in(ext_int_pin_n),
        .sync_out(pin_sync)
    );

    logic pin_enable_q;
    logic mode_q;
    logic mask_q;
    logic latch_q;
    logic [ext_int_pkg::EV_W-1:0] ev_status_q;
    logic [ext_int_pkg::EV_W-1:0] ev_mask_q;
    ext_int_pkg::bus_state_e bus_q;

    // Disabled pin looks permanently high to the interrupt logic.
    wire pin_low = pin_enable_q & ~pin_sync;
    wire prev_low = pin_enable_q & ~pin_prev_q;
    wire falling = pin_low & ~prev_low;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Each access is answered one cycle after it is presented; the first
    // cycle holds waitrequest high so the strobe takes effect only once.
    wire bus_idle = (bus_q == ext_int_pkg::BUS_IDLE);
    wire wr_go = avs_write & bus_idle;
    wire rd_go = avs_read & bus_idle;
    wire be0 = avs_byteenable[0];
    function automatic logic hit(input logic [ext_int_pkg::ADDR_W-1:0] a,
                                 input logic [ext_int_pkg::ADDR_W-1:0] b);
        return a == b;
    endfunction
    wire sel_sc = hit(avs_address, ext_int_pkg::STATUS_CONTROL_ADDR);
    wire sel_cfg = hit(avs_address, ext_int_pkg::CONFIG_TWO_ADDR);
    wire sel_evs = hit(avs_address, ext_int_pkg::EVENT_STATUS_ADDR);
    wire sel_evm = hit(avs_address, ext_int_pkg::EVENT_MASK_ADDR);
    wire wr_sc = wr_go & be0 & sel_sc;
    wire wr_cfg = wr_go & be0 & sel_cfg;
    wire wr_evs = wr_go & be0 & sel_evs;
    wire wr_evm = wr_go & be0 & sel_evm;
    wire sw_ack = wr_sc & avs_writedata[ext_int_pkg::ACK_BIT];
    wire ack = sw_ack | vector_fetch;

    // ------------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------------
    // Only a falling edge sets the latch. The low level in level mode is
    // carried by the pending term instead, so an acknowledge that arrives
    // while the pin is still low clears the latch and the request then
    // ends by itself once the pin returns high, in either order.
    wire set_req = falling;
    // Set wins over acknowledge so an edge in the ack cycle is kept.
    wire latch_d = set_req | (latch_q & ~ack);
    // In level mode a low pin keeps the request pending regardless.
    wire pending = latch_q | (mode_q & pin_low);
    wire req_d = pending & ~mask_q & ~cpu_global_mask;

    wire [ext_int_pkg::EV_W-1:0] ev_set = {ack, set_req};
    wire [ext_int_pkg::EV_W-1:0] ev_clr =
        wr_evs ? avs_writedata[ext_int_pkg::EV_W-1:0] : '0;
    wire [ext_int_pkg::EV_W-1:0] ev_status_d =
        ev_set | (ev_status_q & ~ev_clr);

    function automatic logic [31:0] sc_word(input logic f, input logic m,
                                            input logic md);
        logic [31:0] w;
        w = ext_int_pkg::ZERO_WORD;
        w[ext_int_pkg::FLAG_BIT] = f;
        w[ext_int_pkg::MASK_BIT] = m;
        w[ext_int_pkg::MODE_BIT] = md;
        return w; // ACK bit left zero
    endfunction

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = ext_int_pkg::ZERO_WORD;
        if (sel_sc) begin
            rd_mux = sc_word(pending, mask_q, mode_q);
        end else if (sel_cfg) begin
            rd_mux[ext_int_pkg::PIN_ENABLE_BIT] = pin_enable_q;
        end else if (sel_evs) begin
            rd_mux[ext_int_pkg::EV_W-1:0] = ev_status_q;
        end else if (sel_evm) begin
            rd_mux[ext_int_pkg::EV_W-1:0] = ev_mask_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_q <= ext_int_pkg::RESET_BIT;
            mode_q <= ext_int_pkg::RESET_BIT;
            mask_q <= ext_int_pkg::RESET_BIT;
            pin_enable_q <= ext_int_pkg::RESET_BIT;
            pin_prev_q <= 1'b1;
            irq_request_q <= 1'b0;
            vector_ack_q <= 1'b0;
            ev_status_q <= '0;
            ev_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            pin_prev_q <= pin_sync;
            irq_request_q <= req_d;
            vector_ack_q <= vector_fetch;
            ev_status_q <= ev_status_d;
            irq_q <= |(ev_status_d & ~ev_mask_q);
            if (wr_sc) begin
                mode_q <= avs_writedata[ext_int_pkg::MODE_BIT];
                mask_q <= avs_writedata[ext_int_pkg::MASK_BIT];
            end
            if (wr_cfg) begin
                pin_enable_q <= avs_writedata[ext_int_pkg::PIN_ENABLE_BIT];
            end
            if (wr_evm) begin
                ev_mask_q <= avs_writedata[ext_int_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_q <= ext_int_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= ext_int_pkg::ZERO_WORD;
        end else begin
            if (bus_idle && (avs_read || avs_write)) begin
                bus_q <= ext_int_pkg::BUS_DONE;
                avs_waitrequest <= 1'b0;
            end else begin
                bus_q <= ext_int_pkg::BUS_IDLE;
                avs_waitrequest <= 1'b1;
            end
            if (rd_go) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_edge_sets_latch: assert property (
        falling |=> latch_q) else $error("edge did not latch");
    a_disabled_pin_quiet: assert property (
        !pin_enable_q |-> !falling) else $error("disabled pin triggered");
    a_fetch_clears_edge: assert property (
        vector_fetch && !set_req |=> !latch_q)
        else $error("fetch did not clear");
    a_swack_clears_edge: assert property (
        sw_ack && !set_req |=> !latch_q) else $error("ack did not clear");
    a_edge_holds_latch: assert property (
        latch_q && !ack |=> latch_q) else $error("latch dropped");
    a_level_stays_pending: assert property (
        mode_q && pin_low |-> pending) else $error("level not pending");
    sequence s_level_release;
        mode_q && !pin_low && latch_q && !ack ##1 !latch_q;
    endsequence
    a_level_needs_ack: assert property (
        not s_level_release) else $error("cleared without ack");
    a_mask_withholds: assert property (
        mask_q |=> !irq_request_q) else $error("masked request shown");
    a_global_mask: assert property (
        cpu_global_mask |=> !irq_request_q) else $error("global mask");
    a_unmasked_shown: assert property (
        pending && !mask_q && !cpu_global_mask |=> irq_request_q)
        else $error("request not presented");
    a_ack_reads_zero: assert property (
        rd_go && sel_sc |=> !avs_readdata[ext_int_pkg::ACK_BIT])
        else $error("ack bit read one");

    // ------------------------------------------------------------------
    // Bus protocol checks
    // ------------------------------------------------------------------
    // The slave answers exactly one cycle after it takes a request and
    // never twice in a row, so a master that keeps its strobe up over
    // the answer edge cannot start a second access by accident.
    sequence s_bus_taken;
        bus_idle && (avs_read || avs_write);
    endsequence
    a_bus_answers: assert property (
        s_bus_taken |=> !avs_waitrequest) else $error("no bus answer");
    a_answer_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_no_stray_answer: assert property (
        bus_idle && !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");
    a_read_data_hold: assert property (
        !rd_go |=> $stable(avs_readdata)) else $error("read data moved");
    a_read_data_load: assert property (
        rd_go |=> avs_readdata == $past(rd_mux))
        else $error("read data wrong");

    // ------------------------------------------------------------------
    // Control register checks
    // ------------------------------------------------------------------
    a_mode_written: assert property (
        wr_sc |=> mode_q == $past(avs_writedata[ext_int_pkg::MODE_BIT]))
        else $error("mode not written");
    a_mask_written: assert property (
        wr_sc |=> mask_q == $past(avs_writedata[ext_int_pkg::MASK_BIT]))
        else $error("mask not written");
    a_controls_hold: assert property (
        !wr_sc |=> $stable(mode_q) && $stable(mask_q))
        else $error("control bit moved");
    a_enable_written: assert property (
        wr_cfg |=> pin_enable_q ==
            $past(avs_writedata[ext_int_pkg::PIN_ENABLE_BIT]))
        else $error("enable not written");
    a_enable_holds: assert property (
        !wr_cfg |=> $stable(pin_enable_q)) else $error("enable moved");
    a_flag_readback: assert property (
        rd_go && sel_sc |=>
            avs_readdata[ext_int_pkg::FLAG_BIT] == $past(pending))
        else $error("flag read wrong");
    a_mask_readback: assert property (
        rd_go && sel_sc |=>
            avs_readdata[ext_int_pkg::MASK_BIT] == $past(mask_q))
        else $error("mask read wrong");
    a_mode_readback: assert property (
        rd_go && sel_sc |=>
            avs_readdata[ext_int_pkg::MODE_BIT] == $past(mode_q))
        else $error("mode read wrong");
    a_cfg_readback: assert property (
        rd_go && sel_cfg |=>
            avs_readdata[ext_int_pkg::PIN_ENABLE_BIT] == $past(pin_enable_q))
        else $error("enable read wrong");

    // ------------------------------------------------------------------
    // Latch and request checks
    // ------------------------------------------------------------------
    // An acknowledge must not blind the pin: a fresh fall right after it
    // has to latch again.
    sequence s_ack_then_fall;
        ack && !set_req ##1 falling;
    endsequence
    a_fall_after_ack: assert property (
        s_ack_then_fall |=> latch_q) else $error("new edge lost");
    // In level mode an early acknowledge leaves the request pending on
    // the low pin alone, and the pin going high then ends it.
    sequence s_ack_while_low;
        mode_q && pin_low && ack && !set_req;
    endsequence
    a_level_ack_early: assert property (
        s_ack_while_low ##1 (mode_q && !pin_low) |-> !pending)
        else $error("early ack kept request");
    a_edge_mode_fetch: assert property (
        !mode_q && vector_fetch && !wr_sc && !set_req |=> !pending)
        else $error("edge fetch left request");
    a_fetch_echo: assert property (
        vector_fetch |=> vector_ack_q) else $error("no fetch ack");
    a_echo_single: assert property (
        !vector_fetch |=> !vector_ack_q) else $error("stray fetch ack");
    a_disabled_idle: assert property (
        !pin_enable_q && !latch_q |-> !pending)
        else $error("disabled pin pending");
    a_request_gone: assert property (
        !pending |=> !irq_request_q) else $error("request without cause");

    // ------------------------------------------------------------------
    // Event status and interrupt output checks
    // ------------------------------------------------------------------
    // Event bits are sticky until software writes a one; a set in the
    // same cycle as the clear wins so no event slips through unseen.
    a_event_latch: assert property (
        set_req |=> ev_status_q[ext_int_pkg::EV_LATCH_BIT])
        else $error("latch event lost");
    a_event_ack: assert property (
        ack |=> ev_status_q[ext_int_pkg::EV_ACK_BIT])
        else $error("ack event lost");
    a_event_sticky: assert property (
        ev_status_q[ext_int_pkg::EV_LATCH_BIT] && !wr_evs
            |=> ev_status_q[ext_int_pkg::EV_LATCH_BIT])
        else $error("event dropped");
    a_ack_event_sticky: assert property (
        ev_status_q[ext_int_pkg::EV_ACK_BIT] && !wr_evs
            |=> ev_status_q[ext_int_pkg::EV_ACK_BIT])
        else $error("ack event dropped");
    a_event_cleared: assert property (
        wr_evs && avs_writedata[ext_int_pkg::EV_LATCH_BIT] && !set_req
            |=> !ev_status_q[ext_int_pkg::EV_LATCH_BIT])
        else $error("event not cleared");
    a_ack_event_cleared: assert property (
        wr_evs && avs_writedata[ext_int_pkg::EV_ACK_BIT] && !ack
            |=> !ev_status_q[ext_int_pkg::EV_ACK_BIT])
        else $error("ack event not cleared");
    a_irq_all_masked: assert property (
        &ev_mask_q |=> !irq_q) else $error("masked event irq");
    a_irq_quiet: assert property (
        ev_status_q == '0 && !set_req && !ack |=> !irq_q)
        else $error("irq without event");
    a_irq_shown: assert property (
        set_req && !ev_mask_q[ext_int_pkg::EV_LATCH_BIT] |=> irq_q)
        else $error("event irq missing");
endmodule

/* tb/ext_pin_source.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Far side: whatever drives the active-low interrupt pin
// ----------------------------------------------------------------------
module ext_pin_source (
    input wire logic clock,
    output logic pin_n
);
    // The pin has a pull-up, so it idles high until a source pulls it down.
    initial pin_n = 1'b1;

    // Change the pin just after an edge, then hold it for some cycles.
    task automatic drive(input logic lvl, input int hold);
        @(posedge clock);
        pin_n <= lvl;
        repeat (hold) @(posedge clock);
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end
module tb;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic clock, rstn, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic ext_int_pin_n, vector_fetch, cpu_global_mask;
    logic irq_request_q, vector_ack_q, irq_q;
    int n_mismatch, checks;
    localparam logic [3:0] SC = ext_int_pkg::STATUS_CONTROL_ADDR;
    localparam logic [3:0] CF = ext_int_pkg::CONFIG_TWO_ADDR;
    localparam logic [3:0] EV = ext_int_pkg::EVENT_STATUS_ADDR;
    localparam logic [3:0] EM = ext_int_pkg::EVENT_MASK_ADDR;
    ext_pin_source src_u (.clock(clock), .pin_n(ext_int_pin_n));
    external_interrupt_latch dut_u (.clock(clock), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_int_pin_n(ext_int_pin_n),
        .vector_fetch(vector_fetch), .cpu_global_mask(cpu_global_mask),
        .irq_request_q(irq_request_q), .vector_ack_q(vector_ack_q),
        .irq_q(irq_q));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // Bus and wait helpers
    // ------------------------------------------------------------------
    // Every signal moves by non-blocking assignment just after a rising
    // edge; waitrequest and read data are judged at the rising edges.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK(n < 20, 1'b1, "bus answer")
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e, "read data")
    endtask
    task automatic wait_req(input logic e);
        for (int n = 0; n < 12; n++) begin
            @(negedge clock);
            if (irq_request_q === e) break;
        end
        `CHK(irq_request_q, e, "request level")
    endtask
    task automatic pulse();
        src_u.drive(1'b0, 3);
        src_u.drive(1'b1, 1);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_and_disabled();
        rd(SC, 32'h0);
        rd(CF, 32'h0);
        rd(4'h2, 32'h0);
        pulse();
        repeat (6) @(posedge clock);
        `CHK(irq_request_q, 1'b0, "pin off")
        wr(4'h2, 32'hF);
        rd(SC, 32'h0);
        wr(CF, 32'h1);
        $display("test reset_and_disabled done");
    endtask
    task automatic t_edge();
        pulse();
        wait_req(1'b1);
        repeat (10) @(posedge clock);
        `CHK(irq_request_q, 1'b1, "edge held")
        rd(SC, 32'h8);
        wr(SC, 32'h4);
        wait_req(1'b0);
        pulse();
        wait_req(1'b1);
        @(posedge clock);
        vector_fetch <= 1'b1;
        @(posedge clock);
        vector_fetch <= 1'b0;
        @(negedge clock);
        `CHK(vector_ack_q, 1'b1, "fetch ack")
        wait_req(1'b0);
        $display("test edge done");
    endtask
    task automatic t_mask();
        wr(SC, 32'h2);
        pulse();
        repeat (8) @(posedge clock);
        `CHK(irq_request_q, 1'b0, "masked")
        rd(SC, 32'hA);
        wr(SC, 32'h0);
        wait_req(1'b1);
        @(posedge clock);
        cpu_global_mask <= 1'b1;
        wait_req(1'b0);
        @(posedge clock);
        cpu_global_mask <= 1'b0;
        wait_req(1'b1);
        wr(SC, 32'h4);
        wait_req(1'b0);
        $display("test mask done");
    endtask
    task automatic t_level();
        wr(SC, 32'h1);
        src_u.drive(1'b0, 3);
        wait_req(1'b1);
        wr(SC, 32'h5);
        repeat (6) @(posedge clock);
        `CHK(irq_request_q, 1'b1, "low after ack")
        src_u.drive(1'b1, 1);
        wait_req(1'b0);
        src_u.drive(1'b0, 3);
        wait_req(1'b1);
        src_u.drive(1'b1, 6);
        `CHK(irq_request_q, 1'b1, "high before ack")
        wr(SC, 32'h5);
        wait_req(1'b0);
        src_u.drive(1'b0, 3);
        wait_req(1'b1);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        `CHK(irq_request_q, 1'b0, "reset low pin")
        rd(SC, 32'h0);
        src_u.drive(1'b1, 1);
        wr(CF, 32'h1);
        $display("test level done");
    endtask
    task automatic t_events();
        pulse();
        wait_req(1'b1);
        rd(EV, 32'h1);
        `CHK(irq_q, 1'b1, "event irq")
        wr(EM, 32'h3);
        repeat (2) @(posedge clock);
        `CHK(irq_q, 1'b0, "event masked")
        wr(EM, 32'h0);
        wr(SC, 32'h4);
        rd(EV, 32'h3);
        wr(EV, 32'h3);
        rd(EV, 32'h0);
        `CHK(irq_q, 1'b0, "event cleared")
        $display("test events done");
    endtask
    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // The whole run needs about 200 cycles; thirty times that is a hang.
    initial begin
        #240000;
        n_mismatch++;
        summarize();
    end
    initial begin
        n_mismatch = 0;
        checks = 0;
        rstn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        vector_fetch = 1'b0;
        cpu_global_mask = 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        t_reset_and_disabled();
        t_edge();
        t_mask();
        t_level();
        t_events();
        summarize();
    end
endmodule
